/* design/cpsc_slot_control.sv */
`timescale 1ns/1ps
`default_nettype none
module cpsc_slot_control
    import cpsc_pkg::*;
(
    input wire logic i_clk,              // CPU clock, 200 MHz
    input wire logic i_reset,            // Asynchronous reset, high
    input wire logic i_bus_ready,        // Bus access completes now
    input wire logic [3:0] i_inst_class, // Class of the fetched word
    input wire logic i_inst_on_true,     // Fetched branch tests for true
    input wire logic i_t_flag,           // Current T flag
    output logic o_bus_req,              // Bus access this cycle
    output logic o_bus_fetch,            // Access is an instruction fetch
    output logic o_bus_write,            // Data access is a write
    output logic o_fetch_target,         // Fetch is a branch target
    output logic o_decode_valid,         // Decode stage occupied
    output logic [3:0] o_decode_class,   // Class in decode
    output logic o_alu_valid,            // ALU stage does work
    output logic [3:0] o_alu_class,      // Class in ALU stage
    output logic [1:0] o_seq_stage,      // Trailing stage of long op
    output logic o_multiplier_busy,      // Multiplier still running
    output logic o_slot_stretch,         // Slot stretched on multiplier
    output logic [1:0] o_discard_count   // Fetched words thrown away
);

    // ----------------------------------------------------------------
    // Class decoding
    // ----------------------------------------------------------------
    function automatic logic is_cond(input logic [3:0] c);
        return c == CLS_BCOND || c == CLS_BCOND_DLY;
    endfunction

    function automatic logic is_rmw(input logic [3:0] c);
        return c == CLS_MEM_LOGIC || c == CLS_TAS;
    endfunction

    function automatic logic is_long(input logic [3:0] c);
        return is_rmw(c) || c == CLS_DMUL || c == CLS_MACL;
    endfunction

    function automatic logic [1:0] seq_last(input logic [3:0] c);
        return is_rmw(c) ? LAST_RMW : LAST_MULT;
    endfunction

    function automatic cpsc_stage_t stage_of(input logic [3:0] c,
                                             input logic [1:0] st);
        if (is_rmw(c)) begin
            return (st == STEP_SECOND) ? ST_EX : ST_MA;
        end
        return (st == STEP_SECOND) ? ST_MUL : ST_MA;
    endfunction

    function automatic logic [1:0] hold_of(input logic [3:0] c);
        logic [1:0] h;
        unique case (c)
            CLS_MEM_LOGIC: h = HOLD_MEM_LOGIC;
            CLS_TAS: h = HOLD_TAS;
            CLS_BRANCH: h = HOLD_BRANCH;
            CLS_DMUL, CLS_MACL: h = HOLD_MULT;
            default: h = HOLD_NONE;
        endcase
        return h;
    endfunction

    // ----------------------------------------------------------------
    // State and slot conditions
    // ----------------------------------------------------------------
    cpsc_state_t s_reg;
    cpsc_state_t s_next;
    cpsc_inst_t [1:0] q;
    logic [1:0] cnt;
    logic load;
    logic data_cycle;
    logic freeze;
    logic issue;
    logic take_now;
    logic arrive;
    logic drop;

    // A data access not yet answered, or a stretched slot, stops every
    // stage; only the multiplier keeps counting.
    assign data_cycle = s_reg.bus_req & ~s_reg.bus_fetch;
    assign freeze = (data_cycle & ~i_bus_ready) | s_reg.mult_wait;
    assign issue = s_reg.dec_valid & ~freeze;
    assign arrive = s_reg.bus_req & s_reg.bus_fetch & i_bus_ready;

    // [RULE11] ALU slot fetch dropped
    // The word fetched in a taken conditional branch's ALU slot is thrown
    // away; a delay slot that is still in flight must be kept instead.
    assign drop = arrive & ~s_reg.bus_target & s_reg.ex_valid
                & s_reg.ex_taken & ((s_reg.ex_cls == CLS_BCOND)
                | ((s_reg.ex_cls == CLS_BCOND_DLY)
                & (s_reg.dec_valid | (s_reg.q_count != 2'h0))));

    // [RULE14] jumps always taken
    // [RULE10] flag tested in decode
    assign take_now = issue & ((is_cond(s_reg.dec_cls)
                      & (s_reg.dec_sense == i_t_flag))
                      | (s_reg.dec_cls == CLS_BRANCH));

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        q = s_reg.q;
        cnt = s_reg.q_count;
        load = 1'b0;
        s_next.discard_cnt = 2'h0;
        // [RULE3] four busy cycles after the access
        if (s_reg.seq_valid && s_reg.seq_stage == ST_MUL
            && s_reg.seq_cls == CLS_DMUL && !freeze) begin
            s_next.mult_cnt = MULT_BUSY_CYCLES;
        end else if (s_reg.mult_cnt != 3'h0) begin
            s_next.mult_cnt = s_reg.mult_cnt - 3'h1;
        end
        if (!freeze) begin
            // Fetched word joins the queue; the queue is never full here
            // because fetch is only asked for with room to spare.
            if (arrive && !drop) begin
                q[cnt[0]] = {i_inst_on_true, i_inst_class};
                cnt = cnt + 2'h1;
            end
            // [RULE13] word after the delay slot dropped
            if (drop) begin
                s_next.discard_cnt = 2'h1;
            end
            // [RULE9] shifts share this slot
            // [RULE4] one ALU slot for plain operations
            s_next.ex_valid = issue;
            s_next.ex_cls = s_reg.dec_cls;
            s_next.ex_taken = take_now;
            // [RULE12] false condition leaves ALU idle
            s_next.ex_active = issue & (take_now | ~is_cond(s_reg.dec_cls));
            // [RULE5] trailing read, ALU and write steps
            if (s_reg.ex_valid && is_long(s_reg.ex_cls)) begin
                s_next.seq_valid = 1'b1;
                s_next.seq_cls = s_reg.ex_cls;
                s_next.seq_step = STEP_FIRST;
            end else if (s_reg.seq_valid
                         && s_reg.seq_step != seq_last(s_reg.seq_cls)) begin
                s_next.seq_step = s_reg.seq_step + 2'h1;
            end else begin
                s_next.seq_valid = 1'b0;
            end
            // [RULE7] decode hold slots per class
            load = (s_reg.hold_cnt <= 2'h1);
            if (issue && hold_of(s_reg.dec_cls) != HOLD_NONE) begin
                s_next.hold_cnt = hold_of(s_reg.dec_cls);
                load = 1'b0;
            end else if (s_reg.hold_cnt != 2'h0) begin
                s_next.hold_cnt = s_reg.hold_cnt - 2'h1;
            end
            // [RULE11] every queued word behind the branch dropped
            if (take_now && s_reg.dec_cls == CLS_BCOND) begin
                load = 1'b0;
                s_next.discard_cnt = cnt;
                cnt = 2'h0;
            // [RULE13] delay slot kept, the word after dropped
            end else if (take_now && cnt > 2'h1) begin
                s_next.discard_cnt = cnt - 2'h1;
                cnt = 2'h1;
            end
            // [RULE17] words wait in the queue while decode is held
            s_next.dec_valid = load && cnt != 2'h0;
            s_next.dec_cls = q[0].cls;
            s_next.dec_sense = q[0].sense;
            if (load && cnt != 2'h0) begin
                q[0] = q[1];
                cnt = cnt - 2'h1;
            end
            s_next.q = q;
            s_next.q_count = cnt;
            // [RULE16] target fetch armed by the ALU slot
            if (s_reg.ex_valid && s_reg.ex_taken) begin
                s_next.tgt_pend = 1'b1;
            end else if (arrive && s_reg.bus_target) begin
                s_next.tgt_pend = 1'b0;
            end
        end
        s_next.seq_stage = s_next.seq_valid
                         ? stage_of(s_next.seq_cls, s_next.seq_step)
                         : ST_NONE;
        // [RULE2] no stall after busy
        // [RULE1] stretch while the multiplier count is above MULT_GO_LEVEL
        s_next.mult_wait = s_next.seq_stage == ST_MUL
                         && s_next.seq_cls == CLS_MACL
                         && s_next.mult_cnt > MULT_GO_LEVEL;
        s_next.mult_busy = s_next.mult_cnt != 3'h0;
        // Bus plan for the coming cycle; a waiting data access is kept
        // steady, a fetch may be withdrawn and asked again.
        if (!(data_cycle && !i_bus_ready)) begin
            s_next.bus_req = 1'b0;
            s_next.bus_fetch = 1'b0;
            s_next.bus_write = 1'b0;
            s_next.bus_target = 1'b0;
            // [RULE6] data access wins over fetch
            if ((s_next.seq_stage == ST_MA || s_next.seq_stage == ST_MUL)
                && !s_next.mult_wait) begin
                s_next.bus_req = 1'b1;
                // [RULE8] write step of the locked sequence
                s_next.bus_write = is_rmw(s_next.seq_cls)
                                 && s_next.seq_step == STEP_WRITE;
            end else if (s_next.mult_wait) begin
                s_next.bus_req = 1'b0;
            end else if (s_next.tgt_pend) begin
                s_next.bus_req = 1'b1;
                s_next.bus_fetch = 1'b1;
                s_next.bus_target = 1'b1;
            // [RULE15] no fetch in a jump's ALU slot
            end else if (!(take_now && s_reg.dec_cls == CLS_BRANCH)
                         && s_next.q_count <= Q_FETCH_ROOM) begin
                s_next.bus_req = 1'b1;
                s_next.bus_fetch = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_reg <= STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, each a state flip-flop
    // ----------------------------------------------------------------
    assign o_bus_req = s_reg.bus_req;
    assign o_bus_fetch = s_reg.bus_fetch;
    assign o_bus_write = s_reg.bus_write;
    assign o_fetch_target = s_reg.bus_target;
    assign o_decode_valid = s_reg.dec_valid;
    assign o_decode_class = s_reg.dec_cls;
    assign o_alu_valid = s_reg.ex_active;
    assign o_alu_class = s_reg.ex_cls;
    assign o_seq_stage = s_reg.seq_stage;
    assign o_multiplier_busy = s_reg.mult_busy;
    assign o_slot_stretch = s_reg.mult_wait;
    assign o_discard_count = s_reg.discard_cnt;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    mult_stretch_a: assert property ( // [RULE1]
        $rose(s_reg.mult_wait) |-> !s_reg.bus_req ##[1:4] !s_reg.mult_wait)
        else $error("stretched slot did not end");
    mult_gap_a: assert property ( // [RULE2]
        (s_reg.seq_stage == ST_MUL && s_reg.seq_cls == CLS_MACL
         && s_reg.mult_cnt <= MULT_GO_LEVEL) |-> s_reg.bus_req
         && !s_reg.bus_fetch && !s_reg.mult_wait)
        else $error("multiplier access stalled needlessly");
    mult_busy_a: assert property ( // [RULE3]
        (s_reg.seq_stage == ST_MUL && s_reg.seq_cls == CLS_DMUL && !freeze)
        |=> s_reg.mult_cnt == MULT_BUSY_CYCLES && s_reg.mult_busy
        ##1 s_reg.mult_cnt == 3'h3)
        else $error("multiplier busy period wrong");
    logic_alu_a: assert property ( // [RULE4]
        (issue && s_reg.dec_cls == CLS_LOGIC) |=> s_reg.ex_active
        && s_reg.ex_cls == CLS_LOGIC && s_reg.hold_cnt == HOLD_NONE)
        else $error("logic op not one ALU slot");
    rmw_hold_a: assert property ( // [RULE5]
        (issue && s_reg.dec_cls == CLS_MEM_LOGIC)
        |=> !s_reg.dec_valid ##1 !s_reg.dec_valid)
        else $error("memory logic hold too short");
    rmw_bus_a: assert property ( // [RULE6]
        (s_reg.seq_stage == ST_MA && s_reg.seq_cls == CLS_MEM_LOGIC)
        |-> s_reg.bus_req && !s_reg.bus_fetch)
        else $error("memory logic access lost the bus");
    tas_hold_a: assert property ( // [RULE7]
        (issue && s_reg.dec_cls == CLS_TAS) |=> !s_reg.dec_valid [*3])
        else $error("test-and-set hold too short");
    tas_write_a: assert property ( // [RULE8]
        (s_reg.seq_stage == ST_MA && s_reg.seq_cls == CLS_TAS
         && s_reg.seq_step == STEP_WRITE) |-> s_reg.bus_write
         && !s_reg.bus_fetch)
        else $error("test-and-set write lost the bus");
    shift_alu_a: assert property ( // [RULE9]
        (issue && s_reg.dec_cls == CLS_SHIFT) |=> s_reg.ex_active
        && !s_reg.ex_taken)
        else $error("shift not one ALU slot");
    cond_test_a: assert property ( // [RULE10]
        (issue && s_reg.dec_cls == CLS_BCOND)
        |=> s_reg.ex_taken == $past(s_reg.dec_sense == i_t_flag))
        else $error("branch condition not taken from decode");
    cond_flush_a: assert property ( // [RULE11]
        (take_now && s_reg.dec_cls == CLS_BCOND) |=> !s_reg.dec_valid
        && s_reg.q_count == 2'h0 && !s_reg.bus_target
        ##1 !s_reg.dec_valid)
        else $error("taken branch kept fetched words");
    cond_idle_a: assert property ( // [RULE12]
        (issue && is_cond(s_reg.dec_cls) && !take_now)
        |=> s_reg.ex_valid && !s_reg.ex_active)
        else $error("false branch used the ALU");
    delay_keep_a: assert property ( // [RULE13]
        (take_now && s_reg.dec_cls == CLS_BCOND_DLY)
        |=> s_reg.q_count == 2'h0 && s_reg.ex_taken)
        else $error("delayed branch kept the wrong word");
    jump_exec_a: assert property ( // [RULE14]
        (issue && s_reg.dec_cls == CLS_BRANCH) |=> s_reg.ex_taken
        && s_reg.ex_active && s_reg.discard_cnt <= 2'h1)
        else $error("jump not executed as delayed");
    jump_hold_a: assert property ( // [RULE15]
        (issue && s_reg.dec_cls == CLS_BRANCH) |=> !s_reg.dec_valid)
        else $error("delay slot decode not held");
    target_fetch_a: assert property ( // [RULE16]
        (s_reg.ex_valid && s_reg.ex_taken && !freeze) |=> s_reg.tgt_pend
        && (s_reg.bus_target || data_cycle || s_reg.mult_wait))
        else $error("target fetch not in next slot");
    stall_keep_a: assert property ( // [RULE17]
        freeze |=> $stable(s_reg.dec_valid) && $stable(s_reg.q_count))
        else $error("stall lost or duplicated a word");

endmodule
`default_nettype wire

/* design/cpsc_pkg.sv */
// Operation
// [RULE1] A long multiply-accumulate right after a signed double multiply stretches its multiplier access slot until the multiplier is free.
// [RULE2] With two or more non-multiplier instructions in between, that pair causes no contention stall.
// [RULE3] After the multiplier access of a double multiply the multiplier stays busy for four cycles.
// [RULE4] Register and immediate logic operations, bit test included, run fetch, decode and one ALU slot.
// [RULE5] Byte logic operations on memory run ALU, read, ALU, write and hold the next decode two slots.
// [RULE6] The memory accesses of byte logic operations win the bus over instruction fetch.
// [RULE7] Test-and-set byte runs the same six stages and holds the next decode three slots.
// [RULE8] The memory accesses of test-and-set byte win the bus over instruction fetch.
// [RULE9] Shifts and rotates of any listed kind run fetch, decode and one ALU slot.
// [RULE10] Plain conditional branches test the flag in decode and have no delay slot.
// [RULE11] A taken plain conditional branch discards the two instructions behind it; target fetch follows its ALU slot.
// [RULE12] A conditional branch found false leaves its ALU slot idle and sequential flow goes on.
// [RULE13] A taken delayed conditional branch runs its delay slot, drops the one after, target fetch follows its ALU slot.
// [RULE14] Unconditional jumps, calls and return are delayed and run their delay slot.
// [RULE15] The decode of an unconditional branch's delay slot is held one cycle.
// [RULE16] The target fetch of an unconditional branch begins in the slot after its ALU slot.
// [RULE17] While decode is held, fetch is held back so nothing is lost or run twice.
package cpsc_pkg;

    // ----------------------------------------------------------------
    // Instruction classes reported by the decoder
    // ----------------------------------------------------------------
    localparam logic [3:0] CLS_OTHER = 4'h0;
    localparam logic [3:0] CLS_LOGIC = 4'h1;
    localparam logic [3:0] CLS_SHIFT = 4'h2;
    localparam logic [3:0] CLS_MEM_LOGIC = 4'h3;
    localparam logic [3:0] CLS_TAS = 4'h4;
    localparam logic [3:0] CLS_BCOND = 4'h5;
    localparam logic [3:0] CLS_BCOND_DLY = 4'h6;
    localparam logic [3:0] CLS_BRANCH = 4'h7;
    localparam logic [3:0] CLS_DMUL = 4'h8;
    localparam logic [3:0] CLS_MACL = 4'h9;

    // ----------------------------------------------------------------
    // Decode hold slots, sequencer steps and multiplier timing
    // ----------------------------------------------------------------
    localparam logic [1:0] HOLD_NONE = 2'h0;
    localparam logic [1:0] HOLD_MEM_LOGIC = 2'h2;
    localparam logic [1:0] HOLD_TAS = 2'h3;
    localparam logic [1:0] HOLD_BRANCH = 2'h1;
    localparam logic [1:0] HOLD_MULT = 2'h1;
    localparam logic [1:0] STEP_FIRST = 2'h1;
    localparam logic [1:0] STEP_SECOND = 2'h2;
    localparam logic [1:0] STEP_WRITE = 2'h3;
    localparam logic [1:0] LAST_RMW = 2'h3;
    localparam logic [1:0] LAST_MULT = 2'h2;
    localparam logic [2:0] MULT_BUSY_CYCLES = 3'h4;
    localparam logic [2:0] MULT_GO_LEVEL = 3'h1;
    localparam logic [1:0] Q_FETCH_ROOM = 2'h1;

    typedef enum logic [1:0] {ST_NONE, ST_EX, ST_MA, ST_MUL} cpsc_stage_t;

    typedef struct packed {
        logic sense;
        logic [3:0] cls;
    } cpsc_inst_t;

    typedef struct packed {
        cpsc_inst_t [1:0] q;
        logic [1:0] q_count;
        logic dec_valid;
        logic [3:0] dec_cls;
        logic dec_sense;
        logic [1:0] hold_cnt;
        logic ex_valid;
        logic [3:0] ex_cls;
        logic ex_taken;
        logic ex_active;
        logic seq_valid;
        logic [3:0] seq_cls;
        logic [1:0] seq_step;
        cpsc_stage_t seq_stage;
        logic [2:0] mult_cnt;
        logic mult_busy;
        logic mult_wait;
        logic tgt_pend;
        logic bus_req;
        logic bus_fetch;
        logic bus_write;
        logic bus_target;
        logic [1:0] discard_cnt;
    } cpsc_state_t;

    localparam cpsc_state_t STATE_RESET = '0;

endpackage

/* tb/cpsc_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpsc_mem_model
    import cpsc_pkg::*;
(
    input wire logic i_clk,                // CPU clock
    input wire logic i_reset,              // Asynchronous reset, high
    input wire logic i_bus_req,            // Access requested
    input wire logic i_bus_fetch,          // Access is a fetch
    input wire logic i_fetch_target,       // Fetch of a branch target
    input wire logic [15:0][4:0] i_prog,   // Words {on_true, class}
    input wire logic [1:0] i_wait,         // Wait cycles per access
    output logic o_ready,                  // Access completes now
    output logic [3:0] o_cls,              // Class of fetched word
    output logic o_on_true                 // Branch sense of the word
);
    // ----------------------------------------------------------------
    // Program memory with wait states
    // ----------------------------------------------------------------
    logic [3:0] ptr_reg;
    logic [1:0] wait_reg;
    logic [4:0] last_reg;
    logic [3:0] idx;

    // Branch targets always sit at word 8
    assign idx = i_fetch_target ? 4'h8 : ptr_reg;
    assign o_ready = i_bus_req && (wait_reg == i_wait);
    // Off a completed fetch the data lines show the inverse of the last
    // word, so a stale sample can never pass for a fresh one
    assign {o_on_true, o_cls} = (o_ready && i_bus_fetch) ? i_prog[idx] :
                                ~last_reg;

    // Wait counter and fetch pointer
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ptr_reg <= 4'h0;
            wait_reg <= 2'h0;
            last_reg <= 5'h00;
        end else begin
            wait_reg <= (i_bus_req && !o_ready) ? wait_reg + 2'h1 : 2'h0;
            if (o_ready && i_bus_fetch) begin
                ptr_reg <= idx + 4'h1;
                last_reg <= i_prog[idx];
            end
        end
    end
endmodule
`default_nettype wire

/* tb/tb_cpsc_slot_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_cpsc_slot_control
    import cpsc_pkg::*;
;
    localparam logic [4:0] W_OTH = {1'b0, CLS_OTHER};
    localparam logic [4:0] W_LOG = {1'b0, CLS_LOGIC};
    localparam logic [4:0] W_SHF = {1'b0, CLS_SHIFT};
    localparam logic [4:0] W_DMUL = {1'b0, CLS_DMUL};
    localparam logic [4:0] W_MACL = {1'b0, CLS_MACL};
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_t_flag = 1'b0;
    logic [1:0] i_wait = 2'h0;
    logic [15:0][4:0] prog = '0;
    logic ready, on_true, o_bus_req, o_bus_fetch, o_bus_write;
    logic o_fetch_target, o_decode_valid, o_alu_valid;
    logic o_multiplier_busy, o_slot_stretch;
    logic [3:0] cls, o_decode_class, o_alu_class;
    logic [1:0] o_seq_stage, o_discard_count;
    int err_count = 0;
    int n_tests = 0;

    cpsc_slot_control u_cpsc_slot_control (.i_clk(i_clk),
        .i_reset(i_reset), .i_bus_ready(ready), .i_inst_class(cls),
        .i_inst_on_true(on_true), .i_t_flag(i_t_flag),
        .o_bus_req(o_bus_req), .o_bus_fetch(o_bus_fetch),
        .o_bus_write(o_bus_write), .o_fetch_target(o_fetch_target),
        .o_decode_valid(o_decode_valid), .o_decode_class(o_decode_class),
        .o_alu_valid(o_alu_valid), .o_alu_class(o_alu_class),
        .o_seq_stage(o_seq_stage), .o_multiplier_busy(o_multiplier_busy),
        .o_slot_stretch(o_slot_stretch), .o_discard_count(o_discard_count));
    cpsc_mem_model u_cpsc_mem_model (.i_clk(i_clk), .i_reset(i_reset),
        .i_bus_req(o_bus_req), .i_bus_fetch(o_bus_fetch),
        .i_fetch_target(o_fetch_target), .i_prog(prog), .i_wait(i_wait),
        .o_ready(ready), .o_cls(cls), .o_on_true(on_true));

    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic end_sim;
        if (err_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic fail(input logic [3:0] got, input logic [3:0] exp);
        err_count++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) fail({3'h0, got}, {3'h0, exp});
    endtask
    task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) fail(got, exp);
    endtask
    // Inputs always move 1 ns after the rising edge
    task automatic step;
        @(posedge i_clk);
        #1;
    endtask
    // Reloading the program needs a fresh fetch pointer, hence the reset
    task automatic load(input logic [4:0] a, b, c, d, t);
        prog = {35'h0, t, 20'h0, d, c, b, a};
        i_reset = 1'b1;
        step();
        step();
        i_reset = 1'b0;
    endtask
    task automatic wait_dec(input logic [3:0] c);
        int n;
        n = 0;
        while (!(o_decode_valid === 1'b1 && o_decode_class === c) && n < 40)
        begin
            step();
            n++;
        end
        if (n == 40) fail(4'hF, c);
    endtask
    task automatic alu_next(input logic [3:0] c);
        int n;
        n = 0;
        while (o_alu_valid !== 1'b1 && n < 40) begin
            step();
            n++;
        end
        chk_nib(o_alu_valid === 1'b1 ? o_alu_class : 4'hF, c);
        step();
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic s_plain(input logic [1:0] w);
        load(W_LOG, W_SHF, W_OTH, W_LOG, W_OTH);
        i_wait = w;
        alu_next(CLS_LOGIC);
        if (w == 2'h0) chk_bit(o_alu_valid, 1'b1);
        alu_next(CLS_SHIFT);
        alu_next(CLS_OTHER);
        alu_next(CLS_LOGIC);
        i_wait = 2'h0;
    endtask
    task automatic s_rmw(input logic [4:0] op, input logic [1:0] hold);
        logic v3;
        logic [3:0] k3, k4;
        load(op, W_LOG, W_OTH, W_OTH, W_OTH);
        wait_dec(op[3:0]);
        step();
        chk_nib(o_alu_class, op[3:0]);
        chk_bit(o_decode_valid, 1'b0);
        step();
        chk_nib({o_seq_stage, o_bus_req, o_bus_fetch}, 4'hA);
        step();
        v3 = o_decode_valid;
        k3 = o_decode_class;
        chk_nib({2'h0, o_seq_stage}, 4'h1);
        step();
        k4 = o_decode_class;
        chk_nib({o_seq_stage, o_bus_req, o_bus_write}, 4'hB);
        chk_bit(v3, hold == HOLD_MEM_LOGIC);
        chk_nib(hold == HOLD_MEM_LOGIC ? k3 : k4, CLS_LOGIC);
    endtask
    task automatic s_busy;
        load(W_DMUL, W_OTH, W_OTH, W_OTH, W_OTH);
        wait_dec(CLS_DMUL);
        repeat (3) step();
        chk_nib({2'h0, o_seq_stage}, 4'h3);
        for (int i = 0; i < 5; i++) begin
            step();
            chk_bit(o_multiplier_busy, i < 4);
        end
    endtask
    task automatic s_mac(input logic [4:0] b, c, d, input logic [3:0] e);
        logic [3:0] s;
        s = 4'h0;
        load(W_DMUL, b, c, d, W_OTH);
        wait_dec(CLS_DMUL);
        repeat (14) begin
            step();
            if (o_slot_stretch === 1'b1) begin
                s = s + 4'h1;
                chk_bit(o_bus_req, 1'b0);
            end
        end
        chk_nib(s, e);
    endtask
    // Plain or delayed conditional branch, taken when sense matches T
    task automatic s_br(input logic dly, input logic s, input logic t);
        logic tk;
        logic [3:0] d;
        logic [3:0] e;
        tk = (s == t);
        e = tk ? {2'h0, !dly, dly} : 4'h0;
        i_t_flag = t;
        load({s, dly ? CLS_BCOND_DLY : CLS_BCOND}, W_LOG, W_OTH, W_OTH,
             W_SHF);
        wait_dec(dly ? CLS_BCOND_DLY : CLS_BCOND);
        step();
        d = {2'h0, o_discard_count};
        chk_bit(o_alu_valid, tk);
        chk_bit(o_decode_valid, dly || !tk);
        // The ALU slot still fetches the next sequential word
        chk_bit(o_bus_req && o_bus_fetch && !o_fetch_target, 1'b1);
        step();
        chk_bit(o_fetch_target, tk);
        chk_nib(d + {2'h0, o_discard_count}, e);
        if (dly || !tk) alu_next(CLS_LOGIC);
        alu_next(tk ? CLS_SHIFT : CLS_OTHER);
    endtask
    task automatic s_jump;
        logic [3:0] d;
        load({1'b0, CLS_BRANCH}, W_LOG, W_OTH, W_OTH, W_SHF);
        wait_dec(CLS_BRANCH);
        step();
        d = {2'h0, o_discard_count};
        chk_bit(o_decode_valid, 1'b0);
        chk_nib(o_alu_valid ? o_alu_class : 4'hF, CLS_BRANCH);
        step();
        chk_bit(o_fetch_target, 1'b1);
        chk_nib(o_decode_valid ? o_decode_class : 4'hF, CLS_LOGIC);
        chk_nib(d + {2'h0, o_discard_count}, 4'h0);
        alu_next(CLS_LOGIC);
        alu_next(CLS_SHIFT);
    endtask

    // Main sequence; the first load keeps reset high two more cycles
    initial begin
        repeat (18) step();
        s_plain(2'h0);
        s_plain(2'h2);
        s_rmw({1'b0, CLS_MEM_LOGIC}, HOLD_MEM_LOGIC);
        s_rmw({1'b0, CLS_TAS}, HOLD_TAS);
        s_busy();
        s_mac(W_MACL, W_OTH, W_OTH, 4'h2);
        s_mac(W_OTH, W_OTH, W_MACL, 4'h0);
        for (int k = 0; k < 8; k++) s_br(k[2], k[0], k[1]);
        s_jump();
        end_sim();
    end

    // Watchdog, more than ten times the expected run
    initial begin
        #20000;
        err_count++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        end_sim();
    end
endmodule
`default_nettype wire
